// >>> core/tmr8_pkg.sv
package tmr8_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [2:0] ADR_COUNT  = 3'h0;
	localparam logic [2:0] ADR_INTCTL = 3'h1;
	localparam logic [2:0] ADR_OPTION = 3'h2;
	localparam logic [2:0] ADR_STATUS = 3'h3;
	localparam logic [2:0] ADR_MASK   = 3'h4;

	// interrupt_control fields
	localparam int unsigned ICTL_EN_BIT   = 5;
	localparam int unsigned ICTL_FLAG_BIT = 2;

	// timer_option_config fields
	localparam int unsigned OPT_SRC_BIT  = 5;
	localparam int unsigned OPT_EDGE_BIT = 4;
	localparam int unsigned OPT_PSA_BIT  = 3;
	localparam int unsigned OPT_RATE_LSB = 0;
	localparam int unsigned OPT_RATE_W   = 3;

	// status and mask fields
	localparam int unsigned STAT_OVF_BIT = 0;

	// reset values
	localparam logic [7:0] COUNT_RST  = 8'h00;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] PRE_RST    = 8'h00;

	// counting constants
	localparam logic [7:0] COUNT_MAX      = 8'hff;
	localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

	// quarter phases of one instruction cycle
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} tmr8_phase_type;

endpackage : tmr8_pkg

// >>> core/tmr8_qsample.sv
module tmr8_qsample (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic resetn,
	// phase enables
	input  wire logic q2_en,
	input  wire logic q4_en,
	// level to sample and resulting rising-edge pulse
	input  wire logic level_in,
	output logic      rise_pulse
);

	logic s_q2_r;
	logic s_q4_r;
	logic s_prev_r;
	logic pulse_r;
	logic s_q2_nxt;
	logic s_q4_nxt;
	logic s_prev_nxt;
	logic pulse_nxt;

	// sample on q2, resample on q4, edge taken from the q4 copy only
	always_comb begin
		s_q2_nxt   = s_q2_r;
		s_q4_nxt   = s_q4_r;
		s_prev_nxt = s_prev_r;
		pulse_nxt  = 1'b0;
		if (q2_en) begin
			s_q2_nxt = level_in;
		end
		if (q4_en) begin
			s_q4_nxt   = s_q2_r;
			s_prev_nxt = s_q4_r;
			pulse_nxt  = s_q4_r & ~s_prev_r;
		end
	end

	// registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			// after reset the falling-edge setting makes the idle level high; start there to avoid a false edge
			s_q2_r   <= 1'b1;
			s_q4_r   <= 1'b1;
			s_prev_r <= 1'b1;
			pulse_r  <= 1'b0;
		end else begin
			s_q2_r   <= s_q2_nxt;
			s_q4_r   <= s_q4_nxt;
			s_prev_r <= s_prev_nxt;
			pulse_r  <= pulse_nxt;
		end
	end

	assign rise_pulse = pulse_r;

	// edge pulses only follow a q4 sample
	chk_pulse_after_q4: assert property (@(posedge ref_clk) disable iff (!resetn)
		pulse_r |-> $past(q4_en))
		else $error("sampled edge pulse without preceding q4");

endmodule : tmr8_qsample

// >>> core/tmr8_timer.sv
// Summary of operation
// - count wrap from ff to 00 sets overflow flag and requests interrupt
// - overflow flag sets on every wrap regardless of interrupt enable
// - flag is never cleared by hardware; software writes zero to clear
// - overflow request forwarded only while overflow interrupt enable is set
// - counter holds its value during sleep
// - no overflow, hence no wake, can occur while asleep
// - external count path sampled on quarters two and four
// - source select: 1 external pin transitions, 0 instruction cycle clock
// - edge select: 1 high-to-low, 0 low-to-high on external pin
// - prescaler assign: 1 watchdog, 0 timer
// - rate field: timer 1:2 to 1:256, watchdog 1:1 to 1:128
// - without prescaler, timer counts once per instruction cycle
// - count write blocks incrementing for the next two instruction cycles
// - count write clears prescaler while assigned to the timer
// - watchdog clear command clears prescaler while assigned to watchdog
//
// Added by the designer: the plain strobed port and the register offsets.
module tmr8_timer (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// external count pin and power state
	input  wire logic       ext_count_pin,
	input  wire logic       sleep_mode,
	// watchdog side of the prescaler
	input  wire logic       watchdog_tick_in,
	input  wire logic       watchdog_clear_cmd,
	output logic            watchdog_prescaled,
	// interrupts
	output logic            overflow_irq,
	output logic            irq
);

	tmr8_pkg::tmr8_phase_type phase_r;
	tmr8_pkg::tmr8_phase_type phase_nxt;

	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic       flag_r;
	logic       flag_nxt;
	logic       ien_r;
	logic       ien_nxt;
	logic [7:0] option_r;
	logic [7:0] option_nxt;
	logic       stat_r;
	logic       stat_nxt;
	logic       mask_r;
	logic       mask_nxt;
	logic [7:0] pre_r;
	logic [7:0] pre_nxt;
	logic [1:0] inhibit_r;
	logic [1:0] inhibit_nxt;
	logic       pin_prev_r;
	logic       wd_pulse_r;
	logic       wd_pulse_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	logic       cyc_en;
	logic       q2_en;
	logic       q4_en;
	logic       src_ext;
	logic       edge_fall;
	logic       prescaler_assign;
	logic [2:0] rate;
	logic       pin_x;
	logic       pin_edge;
	logic       pre_evt;
	logic       pre_clr;
	logic [7:0] tmask;
	logic [7:0] wmask;
	logic       timer_carry;
	logic       wd_carry;
	logic       ext_level;
	logic       ext_tick;
	logic       tick;
	logic       overflow;
	logic       count_wr;
	logic       ictl_wr;

	// configuration fields
	assign src_ext   = option_r[tmr8_pkg::OPT_SRC_BIT];
	assign edge_fall = option_r[tmr8_pkg::OPT_EDGE_BIT];
	assign prescaler_assign       = option_r[tmr8_pkg::OPT_PSA_BIT];
	assign rate      = option_r[tmr8_pkg::OPT_RATE_LSB +: tmr8_pkg::OPT_RATE_W];
	assign count_wr  = reg_wr && (reg_addr == tmr8_pkg::ADR_COUNT);
	assign ictl_wr   = reg_wr && (reg_addr == tmr8_pkg::ADR_INTCTL);

	// quarter phase sequencer, one instruction cycle per four clocks
	always_comb begin
		case (phase_r)
			tmr8_pkg::PH_Q1: phase_nxt = tmr8_pkg::PH_Q2;
			tmr8_pkg::PH_Q2: phase_nxt = tmr8_pkg::PH_Q3;
			tmr8_pkg::PH_Q3: phase_nxt = tmr8_pkg::PH_Q4;
			tmr8_pkg::PH_Q4: phase_nxt = tmr8_pkg::PH_Q1;
			default:         phase_nxt = tmr8_pkg::PH_Q1;
		endcase
	end
	assign q2_en  = (phase_r == tmr8_pkg::PH_Q2);
	assign q4_en  = (phase_r == tmr8_pkg::PH_Q4);
	assign cyc_en = q4_en;

	// pin polarity and edge detection
	assign pin_x    = ext_count_pin ^ edge_fall;
	assign pin_edge = pin_x & ~pin_prev_r;

	// prescaler ratio masks: timer uses rate+1 bits, watchdog uses rate bits
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_mask
			assign tmask[gi] = (3'(gi) <= rate);
			assign wmask[gi] = (3'(gi) < rate);
		end
	endgenerate

	// shared prescaler routing
	always_comb begin
		if (prescaler_assign) begin
			pre_evt = watchdog_tick_in;
			pre_clr = watchdog_clear_cmd;
		end else begin
			pre_evt = ~sleep_mode & (src_ext ? pin_edge : cyc_en);
			pre_clr = count_wr;
		end
	end
	assign timer_carry = ~prescaler_assign & pre_evt & (&(pre_r | ~tmask));
	assign wd_carry    = prescaler_assign & pre_evt & (&(pre_r | ~wmask));
	assign ext_level   = prescaler_assign ? pin_x : pre_r[rate];

	// external path synchronised on the internal phases
	tmr8_qsample u_qsample (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.q2_en      (q2_en),
		.q4_en      (q4_en),
		.level_in   (ext_level),
		.rise_pulse (ext_tick)
	);

	// count enable: frozen in sleep and during the post-write window
	always_comb begin
		tick = 1'b0;
		if (!sleep_mode && (inhibit_r == 2'h0)) begin
			if (src_ext) begin
				tick = ext_tick;
			end else if (prescaler_assign) begin
				tick = cyc_en;
			end else begin
				tick = timer_carry;
			end
		end
	end
	assign overflow = tick && (count_r == tmr8_pkg::COUNT_MAX);

	// counter, prescaler and write inhibit
	always_comb begin
		count_nxt   = count_r;
		pre_nxt     = pre_r;
		inhibit_nxt = inhibit_r;
		if (count_wr) begin
			count_nxt   = reg_wdata;
			inhibit_nxt = tmr8_pkg::INHIBIT_CYCLES;
		end else begin
			if (tick) begin
				count_nxt = count_r + 8'h01;
			end
			if (cyc_en && (inhibit_r != 2'h0)) begin
				inhibit_nxt = inhibit_r - 2'h1;
			end
		end
		if (pre_clr) begin
			pre_nxt = tmr8_pkg::PRE_RST;
		end else if (pre_evt) begin
			pre_nxt = pre_r + 8'h01;
		end
		wd_pulse_nxt = wd_carry & ~pre_clr;
	end

	// control, flag, status and mask registers
	always_comb begin
		flag_nxt   = flag_r;
		ien_nxt    = ien_r;
		option_nxt = option_r;
		stat_nxt   = stat_r;
		mask_nxt   = mask_r;
		if (ictl_wr) begin
			ien_nxt  = reg_wdata[tmr8_pkg::ICTL_EN_BIT];
			flag_nxt = reg_wdata[tmr8_pkg::ICTL_FLAG_BIT];
		end
		if (overflow) begin
			flag_nxt = 1'b1;
		end
		if (reg_wr && (reg_addr == tmr8_pkg::ADR_OPTION)) begin
			option_nxt = reg_wdata;
		end
		if (reg_wr && (reg_addr == tmr8_pkg::ADR_STATUS) && reg_wdata[tmr8_pkg::STAT_OVF_BIT]) begin
			stat_nxt = 1'b0;
		end
		if (overflow) begin
			stat_nxt = 1'b1;
		end
		if (reg_wr && (reg_addr == tmr8_pkg::ADR_MASK)) begin
			mask_nxt = reg_wdata[tmr8_pkg::STAT_OVF_BIT];
		end
	end

	// read data, valid in the cycle after the read strobe
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				tmr8_pkg::ADR_COUNT: rdata_nxt = count_r;
				tmr8_pkg::ADR_INTCTL: begin
					rdata_nxt[tmr8_pkg::ICTL_EN_BIT]   = ien_r;
					rdata_nxt[tmr8_pkg::ICTL_FLAG_BIT] = flag_r;
				end
				tmr8_pkg::ADR_OPTION: rdata_nxt = option_r;
				tmr8_pkg::ADR_STATUS: rdata_nxt[tmr8_pkg::STAT_OVF_BIT] = stat_r;
				tmr8_pkg::ADR_MASK:   rdata_nxt[tmr8_pkg::STAT_OVF_BIT] = mask_r;
				default:              rdata_nxt = 8'h00;
			endcase
		end
	end

	// state registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase_r    <= tmr8_pkg::PH_Q1;
			count_r    <= tmr8_pkg::COUNT_RST;
			flag_r     <= 1'b0;
			ien_r      <= 1'b0;
			option_r   <= tmr8_pkg::OPTION_RST;
			stat_r     <= 1'b0;
			mask_r     <= 1'b0;
			pre_r      <= tmr8_pkg::PRE_RST;
			inhibit_r  <= 2'h0;
			pin_prev_r <= 1'b1; // idle level of the inverted pin under the reset option value
			wd_pulse_r <= 1'b0;
			rdata_r    <= 8'h00;
		end else begin
			phase_r    <= phase_nxt;
			count_r    <= count_nxt;
			flag_r     <= flag_nxt;
			ien_r      <= ien_nxt;
			option_r   <= option_nxt;
			stat_r     <= stat_nxt;
			mask_r     <= mask_nxt;
			pre_r      <= pre_nxt;
			inhibit_r  <= inhibit_nxt;
			pin_prev_r <= pin_x;
			wd_pulse_r <= wd_pulse_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// outputs
	assign reg_rdata          = rdata_r;
	assign watchdog_prescaled = wd_pulse_r;
	assign overflow_irq       = flag_r & ien_r;
	assign irq                = stat_r & mask_r;

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	chk_flag_on_wrap: assert property (overflow |=> flag_r)
		else $error("wrap did not set overflow flag");
	chk_flag_sticky: assert property (flag_r && !ictl_wr |=> flag_r)
		else $error("overflow flag cleared without software write");
	chk_irq_gated: assert property (!ien_r && !ictl_wr |=> !overflow_irq)
		else $error("overflow request with enable clear");
	chk_irq_forward: assert property (overflow && ien_r && !ictl_wr |=> overflow_irq)
		else $error("enabled overflow did not raise request");
	chk_sleep_hold: assert property (sleep_mode && !count_wr |=> $stable(count_r))
		else $error("counter moved during sleep");
	chk_no_sleep_wrap: assert property (sleep_mode |-> !overflow)
		else $error("overflow while asleep");
	chk_write_inhibit: assert property (count_wr |=> !tick [*5])
		else $error("increment inside post-write window");
	chk_pre_clr_timer: assert property (count_wr && !prescaler_assign |=> pre_r == 8'h00)
		else $error("count write did not clear prescaler");
	chk_pre_clr_wdog: assert property (watchdog_clear_cmd && prescaler_assign |=> pre_r == 8'h00)
		else $error("watchdog clear did not clear prescaler");
	chk_timer_rate: assert property (!src_ext && prescaler_assign && !sleep_mode && inhibit_r == 2'h0
		&& cyc_en && !count_wr |=> count_r == $past(count_r) + 8'h01)
		else $error("timer mode missed an instruction cycle");
	chk_wrap_zero: assert property (overflow && !count_wr |=> count_r == 8'h00)
		else $error("wrap did not restart at zero");
	chk_internal_src: assert property (tick && !src_ext |-> cyc_en)
		else $error("internal count off instruction boundary");
	chk_wdog_rate1: assert property (prescaler_assign && rate == 3'h0 && watchdog_tick_in && !watchdog_clear_cmd
		|=> watchdog_prescaled)
		else $error("watchdog 1:1 did not pass tick");

	cov_overflow: cover property (overflow && ien_r);
	cov_ext_count: cover property (src_ext && tick);
	cov_irq: cover property (irq);
	cov_wdog_out: cover property (watchdog_prescaled);

endmodule : tmr8_timer

// >>> verification/tmr8_ext_src.sv
module tmr8_ext_src (
	// clock
	input  wire logic ref_clk,
	// count pin driven toward the timer
	output logic      ext_count_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// pin rests low until a frame of pulses
	initial ext_count_pin = 1'b0;

	// n full pulses, each level held for half clocks
	task automatic pulses(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			ext_count_pin <= 1'b1;
			repeat (half) @(posedge ref_clk);
			ext_count_pin <= 1'b0;
			repeat (half) @(posedge ref_clk);
		end
	endtask : pulses

	// park the pin at a level long enough to pass the sampler
	task automatic hold_level(input logic b);
		ext_count_pin <= b;
		repeat (8) @(posedge ref_clk);
	endtask : hold_level
endmodule : tmr8_ext_src

// >>> verification/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// design signals
	logic       ref_clk;
	logic       resetn;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       ext_count_pin;
	logic       sleep_mode;
	logic       watchdog_tick_in;
	logic       watchdog_clear_cmd;
	logic       watchdog_prescaled;
	logic       overflow_irq;
	logic       irq;
	// bookkeeping
	int         fails = 0;
	int         n_checks = 0;
	int         cycles = 0;
	int         wd_cnt = 0;
	int         base;
	int         seed;
	int         n;
	logic       rd_d;
	logic [7:0] v;
	logic [7:0] lo_v;
	logic [7:0] hi_v;
	logic [7:0] exp_lo[$];
	logic [7:0] exp_hi[$];

	tmr8_timer DUT (
		.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(ext_count_pin),
		.sleep_mode(sleep_mode), .watchdog_tick_in(watchdog_tick_in),
		.watchdog_clear_cmd(watchdog_clear_cmd), .watchdog_prescaled(watchdog_prescaled),
		.overflow_irq(overflow_irq), .irq(irq)
	);

	tmr8_ext_src src (
		.ref_clk(ref_clk),
		.ext_count_pin(ext_count_pin)
	);

	// 25 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	task automatic bad(input string msg);
		fails++;
		$display("BAD %0t %s", $time, msg);
	endtask : bad

	task automatic idle(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : idle

	// bus cycles: strobe for one edge, then one quiet edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
		exp_lo.push_back(lo);
		exp_hi.push_back(hi);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : rd

	task automatic wdclr();
		watchdog_clear_cmd <= 1'b1;
		@(posedge ref_clk);
		watchdog_clear_cmd <= 1'b0;
		@(posedge ref_clk);
	endtask : wdclr

	task automatic ticks(input int k);
		for (int i = 0; i < k; i++) begin
			watchdog_tick_in <= 1'b1;
			@(posedge ref_clk);
			watchdog_tick_in <= 1'b0;
			@(posedge ref_clk);
		end
	endtask : ticks

	// output checks land mid-cycle, where registered outputs have settled
	task automatic chk_bit(input logic [1:0] e);
		@(negedge ref_clk);
		n_checks++;
		if ({overflow_irq, irq} !== e) bad("interrupt outputs");
		@(posedge ref_clk);
	endtask : chk_bit

	task automatic chk_wd(input int e);
		@(negedge ref_clk);
		n_checks++;
		if (wd_cnt - base != e) bad("watchdog pulse count");
		@(posedge ref_clk);
	endtask : chk_wd

	// cycle count, watchdog pulses and hang guard (runs take about 13000 cycles)
	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		cycles <= cycles + 1;
		if (watchdog_prescaled === 1'b1) wd_cnt <= wd_cnt + 1;
		if (cycles > 60000) begin
			bad("timeout");
			test_done();
		end
	end

	// read data stand in the cycle after the strobe; oldest note is compared
	always @(negedge ref_clk) begin
		if (rd_d === 1'b1) begin
			n_checks++;
			if (exp_lo.size() == 0) begin
				bad("read without a note");
			end else begin
				lo_v = exp_lo.pop_front();
				hi_v = exp_hi.pop_front();
				if (((reg_rdata >= lo_v) && (reg_rdata <= hi_v)) !== 1'b1) bad("read data");
			end
		end
	end

	initial begin
		seed = 32'h6320a0bb;
		resetn = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sleep_mode = 1'b0;
		watchdog_tick_in = 1'b0;
		watchdog_clear_cmd = 1'b0;
		rd_d = 1'b0;
		idle(5);
		resetn <= 1'b1;
		@(posedge ref_clk);
		// reset values and an unmapped place
		rd(tmr8_pkg::ADR_OPTION, 8'hff, 8'hff);
		rd(tmr8_pkg::ADR_COUNT, 8'h00, 8'h00);
		rd(tmr8_pkg::ADR_INTCTL, 8'h00, 8'h00);
		rd(tmr8_pkg::ADR_STATUS, 8'h00, 8'h00);
		rd(tmr8_pkg::ADR_MASK, 8'h00, 8'h00);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h00, 8'h00);
		// watchdog side of the prescaler, every rate
		for (int r = 0; r < 8; r++) begin
			wdclr();
			wr(tmr8_pkg::ADR_OPTION, 8'h08 | 8'(r));
			wdclr();
			base = wd_cnt;
			ticks(3 << r);
			idle(2);
			chk_wd(3);
		end
		wr(tmr8_pkg::ADR_OPTION, 8'h09);
		wdclr();
		base = wd_cnt;
		ticks(1);
		wdclr();
		ticks(1);
		idle(2);
		chk_wd(0);
		// instruction-cycle counting and the write inhibit
		wr(tmr8_pkg::ADR_OPTION, 8'h08);
		wr(tmr8_pkg::ADR_COUNT, 8'h10);
		idle(38);
		rd(tmr8_pkg::ADR_COUNT, 8'h17, 8'h19);
		wr(tmr8_pkg::ADR_COUNT, 8'h20);
		rd(tmr8_pkg::ADR_COUNT, 8'h20, 8'h20);
		// wrap with interrupt enabled and masked through
		wr(tmr8_pkg::ADR_INTCTL, 8'h20);
		wr(tmr8_pkg::ADR_MASK, 8'h01);
		wr(tmr8_pkg::ADR_COUNT, 8'hfe);
		idle(38);
		chk_bit(2'b11);
		rd(tmr8_pkg::ADR_INTCTL, 8'h24, 8'h24);
		rd(tmr8_pkg::ADR_STATUS, 8'h01, 8'h01);
		rd(tmr8_pkg::ADR_COUNT, 8'h06, 8'h08);
		idle(200);
		rd(tmr8_pkg::ADR_INTCTL, 8'h24, 8'h24);
		wr(tmr8_pkg::ADR_INTCTL, 8'h20);
		chk_bit(2'b01);
		wr(tmr8_pkg::ADR_STATUS, 8'h01);
		chk_bit(2'b00);
		// wrap with interrupt disabled still flags
		wr(tmr8_pkg::ADR_INTCTL, 8'h00);
		wr(tmr8_pkg::ADR_MASK, 8'h00);
		wr(tmr8_pkg::ADR_COUNT, 8'hfe);
		idle(38);
		chk_bit(2'b00);
		rd(tmr8_pkg::ADR_INTCTL, 8'h04, 8'h04);
		wr(tmr8_pkg::ADR_INTCTL, 8'h20);
		wr(tmr8_pkg::ADR_STATUS, 8'h01);
		wr(tmr8_pkg::ADR_MASK, 8'h01);
		// sleep freezes the count just below the wrap
		sleep_mode <= 1'b1;
		wr(tmr8_pkg::ADR_COUNT, 8'hfe);
		idle(2000);
		rd(tmr8_pkg::ADR_COUNT, 8'hfe, 8'hfe);
		chk_bit(2'b00);
		repeat (4) begin
			v = 8'($random(seed));
			wr(tmr8_pkg::ADR_COUNT, v);
			rd(tmr8_pkg::ADR_COUNT, v, v);
		end
		sleep_mode <= 1'b0;
		// prescaler moved to the timer, every rate
		for (int r = 0; r < 8; r++) begin
			wdclr();
			wr(tmr8_pkg::ADR_OPTION, 8'(r));
			wr(tmr8_pkg::ADR_COUNT, 8'h00);
			idle((16 << (r + 1)) + 6);
			rd(tmr8_pkg::ADR_COUNT, 8'h03, 8'h05);
		end
		// a count write restarts a prescaler about three quarters full
		wr(tmr8_pkg::ADR_OPTION, 8'h03);
		wr(tmr8_pkg::ADR_COUNT, 8'h00);
		idle(46);
		wr(tmr8_pkg::ADR_COUNT, 8'h00);
		idle(54);
		rd(tmr8_pkg::ADR_COUNT, 8'h00, 8'h00);
		// external pin through the prescaler at 1:2
		wr(tmr8_pkg::ADR_OPTION, 8'h20);
		wr(tmr8_pkg::ADR_COUNT, 8'h00);
		idle(10);
		n = 1 + ($unsigned($random(seed)) % 8);
		src.pulses(2 * n, 4);
		idle(20);
		rd(tmr8_pkg::ADR_COUNT, 8'(n), 8'(n));
		// move the prescaler to the watchdog, then count pin edges directly
		wdclr();
		wr(tmr8_pkg::ADR_COUNT, 8'h00);
		wr(tmr8_pkg::ADR_OPTION, 8'h28);
		wdclr();
		for (int e = 0; e < 2; e++) begin
			wr(tmr8_pkg::ADR_OPTION, (e == 1) ? 8'h38 : 8'h28);
			src.hold_level(1'b0);
			wr(tmr8_pkg::ADR_COUNT, 8'h00);
			idle(10);
			n = 1 + ($unsigned($random(seed)) % 8);
			src.pulses(n, 4);
			src.hold_level(1'b1);
			idle(20);
			rd(tmr8_pkg::ADR_COUNT, 8'(n + 1 - e), 8'(n + 1 - e));
		end
		test_done();
	end
endmodule : testbench
